// *** rtl/iefl_pkg.sv ***
// Constants for the interrupt enable and flag logic
package iefl_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] IEFL_CTRL_OFS     = 8'h00;
    localparam logic [7:0] IEFL_PIE_OFS      = 8'h04;
    localparam logic [7:0] IEFL_PIR_OFS      = 8'h08;
    localparam logic [7:0] IEFL_PCMASK_OFS   = 8'h0C;
    localparam logic [7:0] IEFL_CFG_OFS      = 8'h10;
    localparam logic [7:0] IEFL_T0COUNT_OFS  = 8'h14;

    // Reset values
    localparam logic [7:0] IEFL_CTRL_RST     = 8'h00;
    localparam logic [7:0] IEFL_PIE_RST      = 8'h00;
    localparam logic [7:0] IEFL_PIR_RST      = 8'h00;
    localparam logic [7:0] IEFL_PCMASK_RST   = 8'h00;
    localparam logic [7:0] IEFL_CFG_RST      = 8'h01;

    // Control register fields
    localparam int IEFL_GIE_BIT    = 7;
    localparam int IEFL_PERIPH_IRQ_ENABLE_BIT   = 6;
    localparam int IEFL_TIMER0_OVERFLOW_ENABLE_BIT   = 5;
    localparam int IEFL_EXTIE_BIT  = 4;
    localparam int IEFL_PCIE_BIT   = 3;
    localparam int IEFL_TIMER0_OVERFLOW_FLAG_BIT   = 2;
    localparam int IEFL_EXTIF_BIT  = 1;
    localparam int IEFL_PCIF_BIT   = 0;

    // Peripheral enable and request fields
    localparam int IEFL_ADC_BIT    = 6;
    localparam int IEFL_CCP_BIT    = 5;
    localparam int IEFL_CMP_BIT    = 3;
    localparam int IEFL_T2_BIT     = 1;
    localparam int IEFL_T1_BIT     = 0;
    localparam logic [7:0] IEFL_PERIPH_IMPL = 8'h6B;

    // Configuration fields
    localparam int IEFL_EDGE_BIT   = 0;
    localparam int IEFL_CCPM_LSB   = 1;

    // Capture/compare operating modes
    typedef enum logic [1:0] {
        IEFL_CCP_OFF     = 2'b00,
        IEFL_CCP_CAPTURE = 2'b01,
        IEFL_CCP_COMPARE = 2'b10,
        IEFL_CCP_PWM     = 2'b11
    } iefl_ccp_mode_t;

    // Sticky flag update: hardware set wins over a software write
    function automatic logic iefl_sticky(input logic flag,
                                         input logic wr,
                                         input logic wval,
                                         input logic set);
        iefl_sticky = (wr ? wval : flag) | set;
    endfunction

endpackage

// *** rtl/iefl_reg_if.sv ***
// Register access carrier between the bus slave and the register file
`timescale 1ns/100ps
interface iefl_reg_if;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr_en;
    logic [7:0]  rdata;
    logic        addr_ok;

    modport slave_side (output addr, output wdata, output wr_en,
                        input rdata, input addr_ok);
    modport regs_side  (input addr, input wdata, input wr_en,
                        output rdata, output addr_ok);
endinterface

// *** rtl/iefl_apb_slave.sv ***
// APB slave front end with one wait-free access phase
`timescale 1ns/100ps
module iefl_apb_slave
    import iefl_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    iefl_reg_if.slave_side   regs
);
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        setup;

    assign setup       = psel_in & ~penable_in;
    assign regs.addr   = paddr_in;
    assign regs.wdata  = pwdata_in[7:0];
    // Write lands only at the completing edge, never on error
    assign regs.wr_en  = psel_in & penable_in & pready_ff & pwrite_in
                         & ~pslverr_ff;

    // Ready rises for the access phase that follows each setup
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            pready_ff <= 1'b0;
        else
            pready_ff <= setup;
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (setup)
        begin
            prdata_ff  <= (pwrite_in || !regs.addr_ok) ? 32'h0000_0000
                          : {24'h00_0000, regs.rdata};
            pslverr_ff <= ~regs.addr_ok;
        end
        else
            pslverr_ff <= 1'b0;                   // Error stands one cycle
    end

    assign prdata_out  = prdata_ff;
    assign pready_out  = pready_ff;
    assign pslverr_out = pslverr_ff;
endmodule

// *** rtl/iefl_edge_det.sv ***
// Per-bit change, rise and fall detector for synchronous inputs
`timescale 1ns/100ps
module iefl_edge_det #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_in,
    input  wire logic         reset_in,
    input  wire logic [W-1:0] sig_in,
    output logic      [W-1:0] change_out,
    output logic      [W-1:0] rise_out,
    output logic      [W-1:0] fall_out
);
    logic [W-1:0] prev_ff;
    logic         armed_ff;

    // Previous level, armed one cycle after reset to avoid false edges
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            prev_ff  <= '0;
            armed_ff <= 1'b0;
        end
        else
        begin
            prev_ff  <= sig_in;
            armed_ff <= 1'b1;
        end
    end

    assign change_out = armed_ff ? (sig_in ^ prev_ff) : '0;
    assign rise_out   = change_out & sig_in;
    assign fall_out   = change_out & prev_ff;
endmodule

// *** rtl/iefl_top.sv ***
// Interrupt enable and flag register file with interrupt request output
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
module iefl_top
    import iefl_pkg::*;
#(
    parameter int GPIO_W = 6
) (
    input  wire logic              clk_sys_in,
    input  wire logic              reset_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [7:0]        paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              timer0_tick_in,
    input  wire logic [GPIO_W-1:0] gpio_in,
    input  wire logic              ext_irq_pin_in,
    input  wire logic              comparator_out_in,
    input  wire logic              adc_start_in,
    input  wire logic              adc_done_in,
    input  wire logic              capture_event_in,
    input  wire logic              compare_match_in,
    input  wire logic              timer2_period_match_in,
    input  wire logic              timer1_overflow_in,
    output logic                   irq_out
);

    // Refuse pin counts the mask register cannot hold
    generate
        if (GPIO_W < 1 || GPIO_W > 6)
        begin : g_bad_width
            $error("GPIO_W must lie between 1 and 6");
        end
    endgenerate

    localparam int EW = GPIO_W + 2;
    // Positions of the two single pins in the edge detector vector
    localparam int EXT_IDX = GPIO_W;
    localparam int CMP_IDX = GPIO_W + 1;


    iefl_reg_if regs ();

    logic [7:0]        interrupt_control_ff;
    logic [7:0]        peripheral_irq_enable_ff;
    logic [7:0]        peripheral_irq_request_ff;
    logic [GPIO_W-1:0] pin_change_mask_ff;
    logic [7:0]        config_ff;
    logic [7:0]        timer0_count_ff;
    logic              irq_ff;

    logic [7:0]        nxt_interrupt_control;
    logic [7:0]        nxt_peripheral_irq_request;
    logic [7:0]        nxt_timer0_count;
    logic              nxt_irq;

    logic [EW-1:0]     ev_change;
    logic [EW-1:0]     ev_rise;
    logic [EW-1:0]     ev_fall;
    logic [EW-1:0]     ev_levels;

    logic              wr_ctrl;
    logic              wr_pie;
    logic              wr_pir;
    logic              wr_mask;
    logic              wr_cfg;
    logic              wr_t0;

    logic              ext_edge_select;
    iefl_ccp_mode_t    ccp_mode;
    logic              timer0_rollover;
    logic              ext_event;
    logic              pin_change_event;
    logic              ccp_event;
    logic              core_pending;
    logic              periph_pending;
    logic              comparator_event;
    logic              adc_flag_kept;

    // Bus front end
    iefl_apb_slave u_apb (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .psel_in    (psel_in),
        .penable_in (penable_in),
        .pwrite_in  (pwrite_in),
        .paddr_in   (paddr_in),
        .pwdata_in  (pwdata_in),
        .prdata_out (prdata_out),
        .pready_out (pready_out),
        .pslverr_out(pslverr_out),
        .regs       (regs)
    );

    // Pins watched for edges: comparator, external pin, GPIO
    assign ev_levels = {comparator_out_in, ext_irq_pin_in, gpio_in};

    // Edge detection on comparator, external pin and GPIO pins
    iefl_edge_det #(
        .W(EW)
    ) u_edges (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .sig_in     (ev_levels),
        .change_out (ev_change),
        .rise_out   (ev_rise),
        .fall_out   (ev_fall)
    );

    // Write strobes, one per mapped register, only on a landing write
    always_comb
    begin
        wr_ctrl = 1'b0;
        wr_pie  = 1'b0;
        wr_pir  = 1'b0;
        wr_mask = 1'b0;
        wr_cfg  = 1'b0;
        wr_t0   = 1'b0;
        if (regs.wr_en)
        begin
            case (regs.addr)
                IEFL_CTRL_OFS:    wr_ctrl = 1'b1;
                IEFL_PIE_OFS:     wr_pie  = 1'b1;
                IEFL_PIR_OFS:     wr_pir  = 1'b1;
                IEFL_PCMASK_OFS:  wr_mask = 1'b1;
                IEFL_CFG_OFS:     wr_cfg  = 1'b1;
                IEFL_T0COUNT_OFS: wr_t0   = 1'b1;
                default:          wr_ctrl = 1'b0;
            endcase
        end
    end

    // Configuration fields
    assign ext_edge_select = config_ff[IEFL_EDGE_BIT];
    assign ccp_mode = iefl_ccp_mode_t'(config_ff[IEFL_CCPM_LSB +: 2]);

    // Source events, each independent of its enables
    assign timer0_rollover = timer0_tick_in && !wr_t0
                             && (timer0_count_ff == 8'hFF);
    assign ext_event = ext_edge_select ? ev_rise[EXT_IDX]
                                       : ev_fall[EXT_IDX];
    assign pin_change_event =
        |(ev_change[GPIO_W-1:0] & pin_change_mask_ff);
    // Comparator flag fires on either output edge
    assign comparator_event = ev_change[CMP_IDX];
    // Capture and compare share one flag; PWM ignores both
    always_comb
    begin
        case (ccp_mode)
            IEFL_CCP_CAPTURE: ccp_event = capture_event_in;
            IEFL_CCP_COMPARE: ccp_event = compare_match_in;
            IEFL_CCP_PWM:     ccp_event = 1'b0;
            IEFL_CCP_OFF:     ccp_event = 1'b0;
            default:          ccp_event = 1'b0;
        endcase
    end

    // Timer0 count: loads from software, counts on the tick enable
    always_comb
    begin
        if (wr_t0)
            nxt_timer0_count = regs.wdata;
        else if (timer0_tick_in)
            nxt_timer0_count = timer0_count_ff + 8'h01;
        else
            nxt_timer0_count = timer0_count_ff;
    end

    // Count register deliberately has no reset branch
    always_ff @(posedge clk_sys_in)
    begin
        timer0_count_ff <= nxt_timer0_count;
    end

    // Core control register: enables written, flags sticky
    always_comb
    begin
        nxt_interrupt_control = interrupt_control_ff;
        if (wr_ctrl)
            nxt_interrupt_control[7:3] = regs.wdata[7:3];
        nxt_interrupt_control[IEFL_TIMER0_OVERFLOW_FLAG_BIT] = iefl_sticky(
            interrupt_control_ff[IEFL_TIMER0_OVERFLOW_FLAG_BIT], wr_ctrl,
            regs.wdata[IEFL_TIMER0_OVERFLOW_FLAG_BIT], timer0_rollover);
        nxt_interrupt_control[IEFL_EXTIF_BIT] = iefl_sticky(
            interrupt_control_ff[IEFL_EXTIF_BIT], wr_ctrl,
            regs.wdata[IEFL_EXTIF_BIT], ext_event);
        nxt_interrupt_control[IEFL_PCIF_BIT] = iefl_sticky(
            interrupt_control_ff[IEFL_PCIF_BIT], wr_ctrl,
            regs.wdata[IEFL_PCIF_BIT], pin_change_event);
    end

    // Control register state, flags set whatever the enables hold
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            interrupt_control_ff <= IEFL_CTRL_RST;
        else
            interrupt_control_ff <= nxt_interrupt_control;
    end

    // Peripheral enable register, unimplemented bits held at zero
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            peripheral_irq_enable_ff <= IEFL_PIE_RST;
        else if (wr_pie)
            peripheral_irq_enable_ff <=
                regs.wdata & IEFL_PERIPH_IMPL;
    end

    // Starting a conversion clears the completion flag
    assign adc_flag_kept = peripheral_irq_request_ff[IEFL_ADC_BIT]
                           & ~adc_start_in;

    // Peripheral request flags, hardware set wins over a clear
    always_comb
    begin
        nxt_peripheral_irq_request = 8'h00;
        nxt_peripheral_irq_request[IEFL_ADC_BIT] = iefl_sticky(
            adc_flag_kept, wr_pir,
            regs.wdata[IEFL_ADC_BIT], adc_done_in);
        nxt_peripheral_irq_request[IEFL_CCP_BIT] = iefl_sticky(
            peripheral_irq_request_ff[IEFL_CCP_BIT], wr_pir,
            regs.wdata[IEFL_CCP_BIT], ccp_event);
        nxt_peripheral_irq_request[IEFL_CMP_BIT] = iefl_sticky(
            peripheral_irq_request_ff[IEFL_CMP_BIT], wr_pir,
            regs.wdata[IEFL_CMP_BIT], comparator_event);
        nxt_peripheral_irq_request[IEFL_T2_BIT] = iefl_sticky(
            peripheral_irq_request_ff[IEFL_T2_BIT], wr_pir,
            regs.wdata[IEFL_T2_BIT], timer2_period_match_in);
        nxt_peripheral_irq_request[IEFL_T1_BIT] = iefl_sticky(
            peripheral_irq_request_ff[IEFL_T1_BIT], wr_pir,
            regs.wdata[IEFL_T1_BIT], timer1_overflow_in);
    end

    // Peripheral request register state
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            peripheral_irq_request_ff <= IEFL_PIR_RST;
        else
            peripheral_irq_request_ff <=
                nxt_peripheral_irq_request;
    end

    // Pin-change mask register
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            pin_change_mask_ff <= IEFL_PCMASK_RST[GPIO_W-1:0];
        else if (wr_mask)
            pin_change_mask_ff <= regs.wdata[GPIO_W-1:0];
    end

    // Configuration register: edge select and capture/compare mode
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            config_ff <= IEFL_CFG_RST;
        else if (wr_cfg)
            config_ff <= {5'h00, regs.wdata[2:0]};
    end

    // Enabled core sources
    assign core_pending =
        (interrupt_control_ff[IEFL_TIMER0_OVERFLOW_ENABLE_BIT]
         & interrupt_control_ff[IEFL_TIMER0_OVERFLOW_FLAG_BIT])
      | (interrupt_control_ff[IEFL_EXTIE_BIT]
         & interrupt_control_ff[IEFL_EXTIF_BIT])
      | (interrupt_control_ff[IEFL_PCIE_BIT]
         & interrupt_control_ff[IEFL_PCIF_BIT]);

    // Enabled peripheral sources, each gated by its own enable
    assign periph_pending =
        |(peripheral_irq_enable_ff & peripheral_irq_request_ff
          & IEFL_PERIPH_IMPL);

    // Request combines the global and peripheral enables
    assign nxt_irq = interrupt_control_ff[IEFL_GIE_BIT]
        & (core_pending
           | (interrupt_control_ff[IEFL_PERIPH_IRQ_ENABLE_BIT]
              & periph_pending));

    // Registered interrupt request
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            irq_ff <= 1'b0;
        else
            irq_ff <= nxt_irq;
    end

    assign irq_out = irq_ff;

    // Read mux and address check for the bus front end
    always_comb
    begin
        regs.addr_ok = 1'b1;
        regs.rdata   = 8'h00;
        case (regs.addr)
            IEFL_CTRL_OFS:    regs.rdata = interrupt_control_ff;
            IEFL_PIE_OFS:     regs.rdata = peripheral_irq_enable_ff;
            IEFL_PIR_OFS:     regs.rdata = peripheral_irq_request_ff;
            IEFL_PCMASK_OFS:  regs.rdata =
                8'(pin_change_mask_ff);
            IEFL_CFG_OFS:     regs.rdata = config_ff;
            IEFL_T0COUNT_OFS: regs.rdata = timer0_count_ff;
            default:          regs.addr_ok = 1'b0;
        endcase
    end

endmodule

// *** test/iefl_top_props.sv ***
// Port-level assertions for the interrupt enable and flag block
`timescale 1ns/100ps
module iefl_top_props
    import iefl_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [31:0] prdata_out,
    input  wire logic        pready_out,
    input  wire logic        pslverr_out,
    input  wire logic        timer1_overflow_in,
    input  wire logic        irq_out
);
    logic [7:0] ctrl_ff;
    logic       t1en_ff;
    logic       wr_done;
    logic       setup;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    // Completed write and setup phase
    assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
    assign setup = psel_in && !penable_in;

    // Shadow of the control register
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            ctrl_ff <= 8'h00;
        else if (wr_done && paddr_in == IEFL_CTRL_OFS)
            ctrl_ff <= pwdata_in[7:0];
    end

    // Shadow of the timer1 enable
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
            t1en_ff <= 1'b0;
        else if (wr_done && paddr_in == IEFL_PIE_OFS)
            t1en_ff <= pwdata_in[IEFL_T1_BIT];
    end

    AST_READY_AFTER_SETUP:
        assert property (setup |=> pready_out)
        else $error("pready missing after setup");
    AST_READY_ONE_CYCLE:
        assert property (pready_out |=> !pready_out)
        else $error("pready held too long");
    AST_ERR_WITH_READY:
        assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    AST_UPPER_ZERO:
        assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_UNMAPPED:
        assert property (setup && paddr_in > 8'h14 |=> pslverr_out)
        else $error("unmapped access not refused");
    AST_PERIPH_UNIMPL:
        assert property (pready_out && !pwrite_in
            && (paddr_in == IEFL_PIE_OFS || paddr_in == IEFL_PIR_OFS)
            |-> {prdata_out[7], prdata_out[4], prdata_out[2]} == 3'b000)
        else $error("unimplemented peripheral bit reads one");
    AST_GLOBAL_OFF:
        assert property ((!ctrl_ff[IEFL_GIE_BIT])[*2] |-> !irq_out)
        else $error("request with global enable clear");
    AST_ENABLES_OFF:
        assert property ((ctrl_ff[6:3] == 4'h0)[*2] |-> !irq_out)
        else $error("request with every enable clear");
    AST_T1_IRQ:
        assert property (timer1_overflow_in && ctrl_ff[7] && ctrl_ff[6]
            && t1en_ff && !wr_done |-> ##2 irq_out)
        else $error("timer1 overflow gave no request");

    COV_WRITE: cover property (wr_done && paddr_in == IEFL_CTRL_OFS);
    COV_IRQ: cover property (irq_out);
    COV_ERR: cover property (pslverr_out);
endmodule

bind iefl_top iefl_top_props u_iefl_top_props (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .timer1_overflow_in(timer1_overflow_in), .irq_out(irq_out));

// *** test/iefl_top_tb.sv ***
// Self-checking bench for the interrupt enable and flag block
`timescale 1ns/100ps
module iefl_top_tb
    import iefl_pkg::*;
;
    logic        clk_sys_in;
    logic        reset_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [5:0]  gpio_in;
    logic        ext_irq_pin_in;
    logic        comparator_out_in;
    logic [6:0]  pul;
    logic        irq_out;
    logic [31:0] seed;
    logic [31:0] rdv;
    logic        errv;
    logic [31:0] c;
    logic [31:0] pe;
    logic [31:0] pr;
    int          bad_count;
    int          total_checks;
    int          k;
    logic [7:0]  ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [7:0]  rstv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    int          pidx [3] = '{2, 5, 6};
    int          pbit [3] = '{6, 1, 0};

    iefl_top u_iefl_top (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .timer0_tick_in(pul[0]),
        .gpio_in(gpio_in), .ext_irq_pin_in(ext_irq_pin_in),
        .comparator_out_in(comparator_out_in), .adc_start_in(pul[1]),
        .adc_done_in(pul[2]), .capture_event_in(pul[3]),
        .compare_match_in(pul[4]), .timer2_period_match_in(pul[5]),
        .timer1_overflow_in(pul[6]), .irq_out(irq_out));

    // Clock generation
    initial
    begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // Comparison with report on mismatch
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // Repeatable xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected request level from register contents
    function automatic logic exp_irq(input logic [7:0] cv,
                                     input logic [7:0] ev,
                                     input logic [7:0] fv);
        return cv[7] && ((|(cv[5:3] & cv[2:0]))
            || (cv[6] && |(ev & fv & 8'h6B)));
    endfunction

    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (pready_out !== 1'b1);
        chk("pready wait", 32'h1, 32'(n));
        rdv = prdata_out;
        errv = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // Register write and checked read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, xs());
        chk(nm, e, rdv);
    endtask

    // Event pulse, idle wait, request check
    task automatic pulse(input int i);
        @(posedge clk_sys_in);
        pul <= 7'h01 << i;
        @(posedge clk_sys_in);
        pul <= 7'h00;
    endtask
    task automatic irqc(input logic e);
        repeat (3) @(posedge clk_sys_in);
        chk("irq", {31'h0, e}, {31'h0, irq_out});
    endtask
    task automatic rst();
        reset_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
    endtask

    // Closing report
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        results();
    end

    // Main sequence
    initial
    begin
        seed = 32'h4145ECC5;
        bad_count = 0;
        total_checks = 0;
        reset_in = 1'b1;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        gpio_in = 6'h00;
        ext_irq_pin_in = 1'b0;
        comparator_out_in = 1'b0;
        pul = 7'h00;
        rst();
        foreach (ofs[i])
            rd(ofs[i], {24'h0, rstv[i]}, "reset value");
        apb(1'b1, 8'hFC, 32'hFF);
        chk("slverr", 32'h1, {31'h0, errv});
        rd(8'h18, 32'h0, "unmapped read");
        chk("slverr", 32'h1, {31'h0, errv});
        repeat (40)
        begin
            c = xs();
            pe = xs();
            pr = xs();
            wr(IEFL_PIR_OFS, pr);
            wr(IEFL_PIE_OFS, pe);
            wr(IEFL_CTRL_OFS, c);
            rd(IEFL_PIE_OFS, pe & 32'h6B, "pie");
            rd(IEFL_PIR_OFS, pr & 32'h6B, "pir");
            rd(IEFL_CTRL_OFS, c & 32'hFF, "ctrl");
            irqc(exp_irq(c[7:0], pe[7:0], pr[7:0]));
        end
        wr(IEFL_CTRL_OFS, 32'h0);
        wr(IEFL_PIE_OFS, 32'h0);
        wr(IEFL_PIR_OFS, 32'h0);
        foreach (pidx[i])
        begin
            pulse(pidx[i]);
            rd(IEFL_PIR_OFS, 32'h1 << pbit[i], "flag");
            wr(IEFL_PIE_OFS, 32'h1 << pbit[i]);
            wr(IEFL_CTRL_OFS, 32'hC0);
            irqc(1'b1);
            wr(IEFL_CTRL_OFS, 32'h80);
            irqc(1'b0);
            wr(IEFL_CTRL_OFS, 32'h40);
            irqc(1'b0);
            wr(IEFL_PIR_OFS, 32'h0);
        end
        wr(IEFL_CTRL_OFS, 32'hC0);
        pulse(6);
        irqc(1'b1);
        wr(IEFL_CTRL_OFS, 32'h0);
        wr(IEFL_PIR_OFS, 32'h0);
        pulse(2);
        pulse(1);
        rd(IEFL_PIR_OFS, 32'h0, "adc start");
        for (int v = 1; v >= 0; v--)
        begin
            comparator_out_in <= v[0];
            rd(IEFL_PIR_OFS, 32'h08, "comparator");
            wr(IEFL_PIR_OFS, 32'h0);
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(IEFL_CFG_OFS, 32'(m * 2 + 1));
            pulse(3);
            rd(IEFL_PIR_OFS, (m == 1) ? 32'h20 : 32'h0, "capture");
            pulse(4);
            rd(IEFL_PIR_OFS, (m == 1 || m == 2) ? 32'h20 : 32'h0,
               "compare");
            wr(IEFL_PIR_OFS, 32'h0);
        end
        for (int s = 1; s >= 0; s--)
        begin
            wr(IEFL_CFG_OFS, 32'(s));
            ext_irq_pin_in <= 1'b1;
            rd(IEFL_CTRL_OFS, s ? 32'h2 : 32'h0, "rise");
            wr(IEFL_CTRL_OFS, 32'h0);
            ext_irq_pin_in <= 1'b0;
            rd(IEFL_CTRL_OFS, s ? 32'h0 : 32'h2, "fall");
            wr(IEFL_CTRL_OFS, 32'h0);
        end
        k = int'(xs() % 6);
        wr(IEFL_PCMASK_OFS, 32'h0);
        gpio_in <= gpio_in ^ (6'h01 << k);
        rd(IEFL_CTRL_OFS, 32'h0, "masked pin");
        wr(IEFL_PCMASK_OFS, 32'h1 << k);
        gpio_in <= gpio_in ^ (6'h01 << k);
        rd(IEFL_CTRL_OFS, 32'h1, "pin change");
        wr(IEFL_CTRL_OFS, 32'h0);
        wr(IEFL_T0COUNT_OFS, 32'hFE);
        pulse(0);
        rd(IEFL_CTRL_OFS, 32'h0, "t0 early");
        pulse(0);
        rd(IEFL_T0COUNT_OFS, 32'h0, "t0 count");
        rd(IEFL_CTRL_OFS, 32'h4, "t0 flag");
        wr(IEFL_T0COUNT_OFS, 32'h5A);
        rst();
        rd(IEFL_T0COUNT_OFS, 32'h5A, "t0 kept");
        rd(IEFL_CTRL_OFS, 32'h0, "ctrl reset");
        results();
    end
endmodule
